// ===== inc/atc_pkg.sv
// Constants, types and register layout for the threshold alert comparator
package atc_pkg;

  // ---------------------------------------------------------------
  // Register pointer values
  // ---------------------------------------------------------------
  localparam logic [1:0] PTR_CONV  = 2'h0;
  localparam logic [1:0] PTR_CFG   = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;

  // ---------------------------------------------------------------
  // Configuration field positions
  // ---------------------------------------------------------------
  localparam int CFG_MODE_BIT   = 8;
  localparam int CFG_CMODE_BIT  = 4;
  localparam int CFG_POL_BIT    = 3;
  localparam int CFG_LAT_BIT    = 2;
  localparam int CFG_QUE_HI     = 1;
  localparam int CFG_QUE_LO     = 0;
  localparam int LIMIT_MSB      = 15;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RST   = 16'h8583;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [15:0] UPPER_RST = 16'h7fff;

  // ---------------------------------------------------------------
  // Queue codes and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] QUE_ONE     = 2'h0;
  localparam logic [1:0] QUE_TWO     = 2'h1;
  localparam logic [1:0] QUE_FOUR    = 2'h2;
  localparam logic [1:0] QUE_DISABLE = 2'h3;
  localparam logic [2:0] CNT_ONE     = 3'h1;
  localparam logic [2:0] CNT_TWO     = 3'h2;
  localparam logic [2:0] CNT_FOUR    = 3'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RDY_PULSE_NS  = 8000;
  localparam int RDY_PULSE_CYC = (RDY_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RDY_PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_W       = 9;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
  } atc_regs_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } atc_conv_s;

endpackage : atc_pkg

// ===== rtl/atc_top.sv
// Threshold comparator and alert/ready pin logic with link-side register port
`timescale 1ns/100ps
module atc_top
  import atc_pkg::*;
(
  // System clock domain
  input  wire logic                 CLK_SYS,
  input  wire logic                 SRST,
  input  wire logic                 CE,
  // Converter core
  input  wire atc_pkg::atc_conv_s   CONV_IN,
  input  wire logic                 OP_STATUS,
  // Link clock domain register port
  input  wire logic                 LINK_CLK,
  input  wire logic [1:0]           REG_PTR,
  input  wire logic [15:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [15:0]          REG_RDATA,
  // Alert response
  input  wire logic                 ARA_REQ,
  input  wire logic [6:0]           DEV_ADDR,
  output logic                      ARA_ACK,
  output logic      [6:0]           ARA_ADDR,
  // Alert/ready pin
  output logic                      ALERT_O,
  output logic                      ALERT_OE
);
  import atc_pkg::*;

  // ---------------------------------------------------------------
  // Link domain reset
  // ---------------------------------------------------------------
  logic lrst_m_q;
  logic lrst_q;

  // Reset crosses through two flops, so link state lags by two edges
  always_ff @(posedge LINK_CLK) begin
    lrst_m_q <= SRST;
    lrst_q   <= lrst_m_q;
  end

  // ---------------------------------------------------------------
  // Link domain registers
  // ---------------------------------------------------------------
  atc_regs_s   regs_q;
  atc_regs_s   regs_d;
  logic        upd_tgl_q;
  logic        rd_tgl_q;
  logic        ara_tgl_q;
  logic        alert_act;
  logic        alert_lm_q;
  logic        alert_l_q;
  logic        ara_win;
  logic [15:0] rdata_d;
  logic [6:0]  ara_addr_d;
  wire         upd_req = REG_WR && (REG_PTR != PTR_CONV);
  wire         clr_req = REG_RD && (REG_PTR == PTR_CONV);

  always_comb begin
    regs_d = regs_q;
    if (REG_WR) begin
      unique case (REG_PTR)
        PTR_CFG:   regs_d.cfg   = REG_WDATA;
        PTR_LOWER: regs_d.lower = REG_WDATA;
        PTR_UPPER: regs_d.upper = REG_WDATA;
        default:   regs_d = regs_q;
      endcase
    end
  end

  assign rdata_d = (REG_PTR == PTR_CFG)   ? regs_q.cfg :
                   (REG_PTR == PTR_LOWER) ? regs_q.lower :
                   (REG_PTR == PTR_UPPER) ? regs_q.upper : 16'h0000;
  assign ara_win    = ARA_REQ & alert_l_q;
  assign ara_addr_d = ara_win ? DEV_ADDR : ARA_ADDR;

  // Register file
  always_ff @(posedge LINK_CLK) begin
    if (lrst_q) begin
      regs_q.cfg   <= CFG_RST;
      regs_q.lower <= LOWER_RST;
      regs_q.upper <= UPPER_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  // Event toggles; a single flip is held while the system side is frozen, but two flips cancel
  always_ff @(posedge LINK_CLK) begin
    if (lrst_q) begin
      upd_tgl_q <= 1'b0;
      rd_tgl_q  <= 1'b0;
      ara_tgl_q <= 1'b0;
    end else begin
      upd_tgl_q <= upd_tgl_q ^ upd_req;
      rd_tgl_q  <= rd_tgl_q ^ clr_req;
      ara_tgl_q <= ara_tgl_q ^ ara_win;
    end
  end

  // Read data and alert response
  always_ff @(posedge LINK_CLK) begin
    if (lrst_q) begin
      REG_RDATA <= 16'h0000;
      ARA_ACK   <= 1'b0;
      ARA_ADDR  <= 7'h00;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= rdata_d;
      end
      ARA_ACK  <= ara_win;
      ARA_ADDR <= ara_addr_d;
    end
  end

  // Alert state back into the link domain
  always_ff @(posedge LINK_CLK) begin
    if (lrst_q) begin
      alert_lm_q <= 1'b0;
      alert_l_q  <= 1'b0;
    end else begin
      alert_lm_q <= alert_act;
      alert_l_q  <= alert_lm_q;
    end
  end

  // ---------------------------------------------------------------
  // Toggle synchronisers into the system domain
  // ---------------------------------------------------------------
  logic [2:0] tgl_src;
  logic [2:0] tgl_m_q;
  logic [2:0] tgl_s_q;
  logic [2:0] tgl_p_q;
  logic [2:0] tgl_evt;

  assign tgl_src = {ara_tgl_q, rd_tgl_q, upd_tgl_q};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_tsync
      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          tgl_m_q[i] <= 1'b0;
          tgl_s_q[i] <= 1'b0;
          tgl_p_q[i] <= 1'b0;
        end else if (CE) begin
          tgl_m_q[i] <= tgl_src[i];
          tgl_s_q[i] <= tgl_m_q[i];
          tgl_p_q[i] <= tgl_s_q[i];
        end
      end
      assign tgl_evt[i] = tgl_s_q[i] ^ tgl_p_q[i];
    end
  endgenerate

  wire upd_evt = tgl_evt[0];
  wire clr_evt = tgl_evt[1] | tgl_evt[2];

  // ---------------------------------------------------------------
  // System domain copy of the registers
  // ---------------------------------------------------------------
  atc_regs_s sregs_q;

  // Writes spaced closer than the toggle round trip may copy mixed words
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sregs_q.cfg   <= CFG_RST;
      sregs_q.lower <= LOWER_RST;
      sregs_q.upper <= UPPER_RST;
    end else if (CE && upd_evt) begin
      sregs_q <= regs_q;
    end
  end

  // ---------------------------------------------------------------
  // Decoded configuration
  // ---------------------------------------------------------------
  wire       window_mode = sregs_q.cfg[CFG_CMODE_BIT];
  wire       pol_high    = sregs_q.cfg[CFG_POL_BIT];
  wire       latch_en    = sregs_q.cfg[CFG_LAT_BIT];
  wire [1:0] que         = sregs_q.cfg[CFG_QUE_HI:CFG_QUE_LO];
  wire       single_shot = sregs_q.cfg[CFG_MODE_BIT];
  wire       disabled    = (que == QUE_DISABLE);
  wire       rdy_mode    = sregs_q.upper[LIMIT_MSB] &
                           ~sregs_q.lower[LIMIT_MSB];

  wire [2:0] need_cnt = (que == QUE_ONE) ? CNT_ONE :
                        (que == QUE_TWO) ? CNT_TWO : CNT_FOUR;

  // ---------------------------------------------------------------
  // Digital comparison
  // ---------------------------------------------------------------
  wire signed [15:0] res_s   = signed'(CONV_IN.data);
  wire signed [15:0] upper_s = signed'(sregs_q.upper);
  wire signed [15:0] lower_s = signed'(sregs_q.lower);
  wire above = res_s > upper_s;
  wire below = res_s < lower_s;
  // Traditional mode releases only below the lower limit (hysteresis)
  wire out_lim = window_mode ? (above | below) : above;
  wire release_c = window_mode ? ~(above | below) : below;

  logic [2:0] qcnt_q;
  logic [2:0] qcnt_d;
  logic       cmp_q;
  logic       cmp_d;
  wire        conv_new = CONV_IN.valid;
  wire        reach    = out_lim && (qcnt_q + 3'h1 >= need_cnt);

  // Count saturates at four so long runs never wrap
  assign qcnt_d = !conv_new ? qcnt_q :
                  !out_lim  ? 3'h0 :
                  (qcnt_q >= CNT_FOUR) ? qcnt_q : qcnt_q + 3'h1;

  // A set wins over a read, response or release clear in the same cycle; disable and ready mode force a clear over a set
  always_comb begin
    cmp_d = cmp_q;
    if (disabled || rdy_mode) begin
      cmp_d = 1'b0;
    end else if (conv_new && reach) begin
      cmp_d = 1'b1;
    end else if (latch_en) begin
      if (clr_evt) begin
        cmp_d = 1'b0;
      end
    end else if (conv_new && release_c) begin
      cmp_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      qcnt_q <= 3'h0;
      cmp_q  <= 1'b0;
    end else if (CE) begin
      qcnt_q <= (disabled || rdy_mode) ? 3'h0 : qcnt_d;
      cmp_q  <= cmp_d;
    end
  end

  // ---------------------------------------------------------------
  // Conversion-ready pulse
  // ---------------------------------------------------------------
  localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(RDY_PULSE_CYC);
  logic [PULSE_W-1:0] pcnt_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pcnt_q <= '0;
    end else if (CE) begin
      if (conv_new && rdy_mode && !single_shot) begin
        pcnt_q <= PULSE_LEN;
      end else if (pcnt_q != '0) begin
        pcnt_q <= pcnt_q - PULSE_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic pin_q;
  logic oe_q;
  wire  rdy_act = single_shot ? OP_STATUS : (pcnt_q != '0);
  wire  act_lvl = rdy_mode ? rdy_act : cmp_d;
  wire  pin_d   = act_lvl ~^ pol_high;
  // Ready signalling never counts as an alert for the response
  wire  alert_d = ~rdy_mode & cmp_d;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      alert_act <= 1'b0;
      pin_q     <= 1'b1;
      oe_q      <= 1'b0;
    end else if (CE) begin
      alert_act <= alert_d;
      pin_q     <= pin_d;
      oe_q      <= ~disabled;
    end
  end

  assign ALERT_O  = pin_q;
  assign ALERT_OE = oe_q;

endmodule : atc_top

// ===== dv/atc_top_checker.sv
// Port assertions for the threshold alert comparator
`timescale 1ns/100ps
module atc_top_checker (
  // System side
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        CE,
  input wire logic        ALERT_O,
  input wire logic        ALERT_OE,
  // Link side
  input wire logic        LINK_CLK,
  input wire logic [1:0]  REG_PTR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        ARA_REQ,
  input wire logic [6:0]  DEV_ADDR,
  input wire logic        ARA_ACK,
  input wire logic [6:0]  ARA_ADDR
);
  // ------
  // Alert response
  // ------
  ack_addr_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    ARA_ACK |-> ARA_ADDR == DEV_ADDR) else $error("ack address wrong");
  ack_pulse_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    ARA_ACK |=> !ARA_ACK) else $error("ack longer than one cycle");
  ack_cause_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    $rose(ARA_ACK) |-> $past(ARA_REQ)) else $error("ack without request");
  ack_alert_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    ARA_ACK |-> ALERT_OE) else $error("ack while pin floats");
  addr_hold_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    !ARA_ACK |-> $stable(ARA_ADDR)) else $error("address moved without ack");
  // ------
  // Register port and pin
  // ------
  rdata_hold_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    !$past(REG_RD) |-> $stable(REG_RDATA)) else $error("read data moved");
  conv_read_a: assert property (@(posedge LINK_CLK) disable iff (SRST)
    REG_RD && REG_PTR == 2'h0 |=> REG_RDATA == 16'h0000) else $error("ptr 0 not zero");
  ce_freeze_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !CE |=> $stable(ALERT_O) && $stable(ALERT_OE)) else $error("pin moved with CE low");
endmodule : atc_top_checker

bind atc_top atc_top_checker i_atc_top_checker (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE),
  .LINK_CLK(LINK_CLK), .REG_PTR(REG_PTR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .ARA_REQ(ARA_REQ), .DEV_ADDR(DEV_ADDR), .ARA_ACK(ARA_ACK), .ARA_ADDR(ARA_ADDR)
);

// ===== dv/atc_host.sv
// Bus controller model for register access and alert response
`timescale 1ns/100ps
module atc_host (
  // Link side
  input  wire logic        LINK_CLK,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        ARA_ACK,
  output logic      [1:0]  REG_PTR,
  output logic      [15:0] REG_WDATA,
  output logic             REG_WR,
  output logic             REG_RD,
  output logic             ARA_REQ
);
  initial begin
    REG_PTR = 2'h0;
    REG_WDATA = 16'h0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    ARA_REQ = 1'b0;
  end
  // One-cycle strobe, released data shows the inverse
  task automatic put(input logic [1:0] p, input logic [15:0] d, input logic w);
    @(negedge LINK_CLK);
    REG_PTR = p;
    REG_WDATA = d;
    REG_WR = w;
    REG_RD = !w;
    @(negedge LINK_CLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = ~d;
    @(negedge LINK_CLK);
  endtask : put
  task automatic ara(output logic got);
    @(negedge LINK_CLK);
    ARA_REQ = 1'b1;
    @(negedge LINK_CLK);
    got = ARA_ACK;
    ARA_REQ = 1'b0;
    repeat (4) begin
      @(negedge LINK_CLK);
      got = got | ARA_ACK;
    end
  endtask : ara
endmodule : atc_host

// ===== dv/tb_atc_top.sv
// Self-checking bench for the threshold alert comparator
`timescale 1ns/100ps
module tb_atc_top;
  import atc_pkg::*;
  localparam logic [6:0] DEV_ID = 7'h2a; // arbitrary
  logic       clk_sys, srst, ce, op_status, link_clk, reg_wr, reg_rd;
  logic       ara_req, ara_ack, alert_o, alert_oe, got;
  logic [1:0] reg_ptr;
  logic [6:0] ara_addr;
  logic [15:0] reg_wdata, reg_rdata;
  atc_conv_s  conv_in;
  int         err_total, n_tests, cyc, n;
  atc_top i_atc_top (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .CONV_IN(conv_in),
    .OP_STATUS(op_status), .LINK_CLK(link_clk), .REG_PTR(reg_ptr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ARA_REQ(ara_req),
    .DEV_ADDR(DEV_ID), .ARA_ACK(ara_ack), .ARA_ADDR(ara_addr), .ALERT_O(alert_o),
    .ALERT_OE(alert_oe));
  atc_host i_atc_host (.LINK_CLK(link_clk), .REG_RDATA(reg_rdata), .ARA_ACK(ara_ack),
    .REG_PTR(reg_ptr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .ARA_REQ(ara_req));
  // ------
  // Helpers
  // ------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : check
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    i_atc_host.put(p, d, 1'b1);
    repeat (12) @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [1:0] p, input logic [15:0] exp);
    i_atc_host.put(p, 16'h0000, 1'b0);
    check("rdata", reg_rdata, exp);
  endtask : rd
  task automatic conv(input logic [15:0] d);
    @(negedge clk_sys);
    conv_in = '{1'b1, d};
    @(negedge clk_sys);
    conv_in = '{1'b0, ~d};
    repeat (2) @(negedge clk_sys);
  endtask : conv
  task automatic pin(input logic e);
    check("alert", {15'h0, alert_o}, {15'h0, e});
  endtask : pin
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    rd(PTR_LOWER, LOWER_RST);
    rd(PTR_UPPER, UPPER_RST);
    rd(PTR_CFG, CFG_RST);
    check("oe", {15'h0, alert_oe}, 16'h0000);
  endtask : t_reset
  task automatic t_queue;
    wr(PTR_UPPER, 16'h0100);
    wr(PTR_LOWER, 16'h0080);
    for (int q = 0; q < 3; q++) begin
      n = (q == 2) ? 4 : q + 1;
      wr(PTR_CFG, {CFG_RST[15:2], 2'(q)});
      if (q == 0) begin
        ce = 1'b0;
        conv(16'h0200);
        pin(1'b1);
        ce = 1'b1;
      end
      repeat (n - 1) conv(16'h0200);
      pin(1'b1);
      conv(16'h0200);
      pin(1'b0);
      check("oe", {15'h0, alert_oe}, 16'h0001);
      conv(16'h00c0);
      pin(1'b0);
      conv(16'h0010);
      pin(1'b1);
    end
  endtask : t_queue
  task automatic t_latch;
    wr(PTR_CFG, 16'h859c);
    conv(16'h0010);
    pin(1'b1);
    conv(16'h00c0);
    pin(1'b1);
    i_atc_host.ara(got);
    check("ack", {15'h0, got}, 16'h0001);
    check("addr", {9'h0, ara_addr}, {9'h0, DEV_ID});
    repeat (10) @(negedge clk_sys);
    pin(1'b0);
    i_atc_host.ara(got);
    check("ack", {15'h0, got}, 16'h0000);
    conv(16'h0200);
    pin(1'b1);
    rd(PTR_CONV, 16'h0000);
    repeat (10) @(negedge clk_sys);
    pin(1'b0);
  endtask : t_latch
  task automatic t_ready;
    wr(PTR_UPPER, 16'h8000);
    wr(PTR_LOWER, 16'h0000);
    wr(PTR_CFG, 16'h8588);
    op_status = 1'b1;
    repeat (10) @(negedge clk_sys);
    pin(1'b1);
    op_status = 1'b0;
    repeat (4) @(negedge clk_sys);
    pin(1'b0);
    wr(PTR_CFG, 16'h0088);
    conv(16'h1234);
    pin(1'b1);
    repeat (RDY_PULSE_CYC - 2) @(negedge clk_sys);
    pin(1'b1);
    @(negedge clk_sys);
    pin(1'b0);
    wr(PTR_CFG, CFG_RST);
    check("oe", {15'h0, alert_oe}, 16'h0000);
  endtask : t_ready
  // ------
  // Clocks, timeout and sequence
  // ------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    op_status = 1'b1;
    conv_in = '{1'b0, 16'h0000};
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_queue();
    t_latch();
    t_ready();
    print_verdict();
  end
endmodule : tb_atc_top
